// ### bench/eaa_host_model.sv
// Host side of the alert line: the pull-up and the host's interrupt input.
// Assumes the alert pin is split into out and oe by the device.
`timescale 1ns/1ps
`default_nettype none

module eaa_host_model (
   input  wire eaa_pkg::eaa_pin_t pin,
   output var  logic              line_level
);
   import eaa_pkg::*;

   // ----------------------------------------
   // Wired line
   // ----------------------------------------
   // Pull-up wins whenever nobody drives, so a released line reads high
   always_comb begin
      line_level = pin.oe ? pin.out : 1'b1;
   end

endmodule // eaa_host_model

`default_nettype wire

// ### bench/tb_error_alert_aggregator.sv
// Testbench for the error alert aggregator: APB register sequences.
// Assumes eaa_top and the host line model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_error_alert_aggregator;
   import eaa_pkg::*;

   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready;
   logic        pslverr;
   logic        err;
   logic        irq;
   logic        line;
   logic        auto_err_rst = 1'b0;
   logic [3:0]  dec_err_evt = 4'h0;
   logic [3:0]  link_locked = 4'hf;
   eaa_evt_t    evt = '0;
   eaa_pin_t    pin;
   int          n_mismatch = 0;
   int          compares = 0;
   int          cyc = 0;

   always #25 clk = ~clk;

   eaa_top i_eaa_top (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .evt(evt), .dec_err_evt(dec_err_evt), .link_locked(link_locked), .auto_err_rst(auto_err_rst),
      .mfp_in(line), .multi_function_pin(pin), .irq(irq));

   eaa_host_model i_eaa_host_model (.pin(pin), .line_level(line));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // Verdict and end of run
   task test_done;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One APB transfer; no wait count assumed, the timeout cuts a hang
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, exp);
   endtask

   // Settle past the edge so registered outputs have landed
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One-cycle pulse on the event, decode and auto reset inputs
   task pulse(input logic [4:0] e, input logic [3:0] d, input logic a);
      @(posedge clk);
      evt          <= eaa_evt_t'(e);
      dec_err_evt  <= d;
      auto_err_rst <= a;
      @(posedge clk);
      evt          <= '0;
      dec_err_evt  <= 4'h0;
      auto_err_rst <= 1'b0;
   endtask

   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         test_done;
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      // Reset state and a refused access
      rdchk("ctrl", 8'h40, 32'h1);
      rdchk("enable", 8'h48, 32'h0);
      rdchk("thr", 8'h50, 32'h1);
      rdchk("summary", 8'h4c, 32'h0);
      chk("released", {pin.oe, line}, 2'b01);
      apb(1'b0, 8'h00, 32'h0);
      chk("slverr", err, 1'b1);
      wr(8'h4c, 32'h1);
      rdchk("summary ro", 8'h4c, 32'h0);
      // Each event source: latched while masked, alerts once enabled, W1C clears
      for (int i = 0; i < 5; i++) begin
         pulse(5'h01 << i, 4'h0, 1'b0);
         tick(2);
         rdchk("flag", 8'h44, 32'h10 << i);
         wr(8'h48, 32'h1f0 ^ (32'h10 << i));
         tick(1);
         chk("masked irq", {irq, line}, 2'b01);
         wr(8'h48, 32'h10 << i);
         tick(1);
         chk("irq", {irq, line}, 2'b10);
         chk("drive", {pin.oe, pin.out}, 2'b10);
         rdchk("summary", 8'h4c, {31'h0, ~line});
         wr(8'h44, 32'h10 << i);
         tick(1);
         chk("cleared", {irq, line}, 2'b01);
         rdchk("flag clr", 8'h44, 32'h0);
      end
      // Three sources at once: alert holds after one clears, drops when every enable is written off
      wr(8'h48, 32'h1f0);
      pulse(5'h13, 4'h0, 1'b0);
      rdchk("cause", 8'h44, 32'h130);
      wr(8'h44, 32'h10);
      tick(1);
      chk("or held", irq, 1'b1);
      wr(8'h48, 32'h0);
      tick(1);
      chk("mask all", {irq, line}, 2'b01);
      wr(8'h48, 32'h1f0);
      // Event landing in the access cycle of its own clear wins
      fork
         wr(8'h44, 32'h20);
         begin
            @(posedge clk);
            pulse(5'h02, 4'h0, 1'b0);
         end
      join
      rdchk("set wins", 8'h44, 32'h120);
      wr(8'h44, 32'h120);
      tick(1);
      chk("or clr", irq, 1'b0);
      // Decode counter, clear on read
      wr(8'h48, 32'h00f);
      pulse(5'h00, 4'h4, 1'b0);
      tick(2);
      rdchk("dec flag", 8'h44, 32'h4);
      chk("dec irq", irq, 1'b1);
      rdchk("cnt2", 8'h68, 32'h1);
      rdchk("dec flag rd", 8'h44, 32'h0);
      // Threshold of three on link 0
      wr(8'h50, 32'h3);
      for (int k = 1; k <= 3; k++) begin
         pulse(5'h00, 4'h1, 1'b0);
         tick(2);
         rdchk("thr flag", 8'h44, (k == 3) ? 32'h1 : 32'h0);
      end
      pulse(5'h00, 4'h0, 1'b1);
      tick(2);
      rdchk("auto flag", 8'h44, 32'h0);
      rdchk("auto cnt0", 8'h60, 32'h0);
      // Relock on link 1 clears its counter
      wr(8'h50, 32'h1);
      pulse(5'h00, 4'h2, 1'b0);
      tick(2);
      rdchk("lock flag", 8'h44, 32'h2);
      link_locked <= 4'hd;
      repeat (2) @(posedge clk);
      link_locked <= 4'hf;
      tick(3);
      rdchk("relock flag", 8'h44, 32'h0);
      rdchk("relock cnt1", 8'h64, 32'h0);
      // Pin back to general-purpose I/O
      wr(8'h40, 32'h6);
      tick(1);
      chk("gpio hi", {pin.oe, pin.out}, 2'b11);
      tick(3);
      rdchk("gpio in hi", 8'h54, 32'h1);
      wr(8'h40, 32'h4);
      tick(4);
      rdchk("gpio in lo", 8'h54, 32'h0);
      test_done;
   end

endmodule // tb_error_alert_aggregator

`default_nettype wire

// ### core/eaa_consts.svh
// Constants for the error alert aggregator: register indices, field
// positions, reset values. Assumes a 32-bit APB with word-aligned registers.
`ifndef EAA_CONSTS_SVH
`define EAA_CONSTS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define EAA_IDX_CTRL      6'h10
`define EAA_IDX_FLAGS     6'h11
`define EAA_IDX_ENABLE    6'h12
`define EAA_IDX_SUMMARY   6'h13
`define EAA_IDX_THR       6'h14
`define EAA_IDX_GPIO_IN   6'h15
`define EAA_IDX_CNT0      6'h18
`define EAA_IDX_CNT_LAST  6'h1b

// ----------------------------------------
// Source counts and field positions
// ----------------------------------------
`define EAA_NLINK         4
`define EAA_NEVT          5
`define EAA_NSRC          9
`define EAA_FL_EVT_LO     4
`define EAA_FL_LFLT       4
`define EAA_FL_EOM        5
`define EAA_FL_REMOTE     7
`define EAA_CTRL_PIN_EN   0
`define EAA_CTRL_GPIO_OUT 1
`define EAA_CTRL_GPIO_OE  2

// ----------------------------------------
// Reset values and counter saturation limit
// ----------------------------------------
`define EAA_THR_RST       8'h01
`define EAA_CNT_MAX       8'hff
`define EAA_ENABLE_RST    9'h000

`endif

// ### core/eaa_dec_counter.sv
// Saturating 8-bit decode-error counter with threshold flag.
// Assumes err_evt and clr are single-cycle pulses on clk.
`include "eaa_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module eaa_dec_counter (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       err_evt,
   input  wire logic       clr,
   input  wire logic [7:0] thr,
   output var  logic [7:0] cnt,
   output var  logic       decode_fault_flag
);
   import eaa_pkg::*;

   eaa_cnt_st_t st_q;
   eaa_cnt_st_t st_d;

   // Clear then count, so an error in the clearing cycle is not lost
   always_comb begin
      st_d = st_q;
      if (clr) begin
         st_d.cnt = err_evt ? 8'h01 : 8'h00;
      end else if (err_evt && st_q.cnt != `EAA_CNT_MAX) begin
         st_d.cnt = st_q.cnt + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign cnt               = st_q.cnt;
   assign decode_fault_flag = (st_q.cnt >= thr);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_CNT_CLR: assert property (clr && !err_evt && thr != 8'h00 |=> cnt == 8'h00 && !decode_fault_flag)
      else $error("counter not cleared");
   AST_CNT_INC: assert property (err_evt && !clr && cnt != `EAA_CNT_MAX |=> cnt == $past(cnt) + 8'h01)
      else $error("counter did not count");
   // Count that lands on the threshold, threshold left alone after it
   sequence s_reach_thr;
      err_evt && !clr && cnt != `EAA_CNT_MAX && cnt + 8'h01 == thr;
   endsequence

   AST_DEC_FLAG: assert property (s_reach_thr ##1 $stable(thr) |-> decode_fault_flag)
      else $error("threshold flag missing");

endmodule // eaa_dec_counter
`default_nettype wire

// ### core/eaa_pkg.sv
// Types shared by the error alert aggregator modules.
// Assumes eaa_consts.svh is on the include path.
`default_nettype none
`include "eaa_consts.svh"

package eaa_pkg;

   // Single-cycle event inputs from the device functions
   typedef struct packed {
      logic safety;      // Safety monitor event
      logic remote;      // Alert forwarded from the remote link partner
      logic watermark;   // Buffer watermark error
      logic eom;         // Eye-opening monitor error
      logic line_fault;  // Line fault error
   } eaa_evt_t;

   // Two-signal view of the multi-function pin
   typedef struct packed {
      logic out;
      logic oe;
   } eaa_pin_t;

   // Register state of the top module
   typedef struct packed {
      logic                       pin_en;
      logic                       gpio_out;
      logic                       gpio_oe;
      logic [`EAA_NEVT-1:0]       evt_flags;
      logic [`EAA_NSRC-1:0]       enable;
      logic [7:0]                 thr;
      logic [`EAA_NLINK-1:0]      lock_prev;
      logic [31:0]                rdata;
   } eaa_top_st_t;

   typedef struct packed {
      logic [7:0] cnt;
   } eaa_cnt_st_t;

   typedef struct packed {
      logic s1;
      logic s2;
   } eaa_sync_st_t;

endpackage
`default_nettype wire

// ### core/eaa_sync2.sv
// Two-flop synchroniser for the multi-function pin input.
// Assumes the input is asynchronous to clk.
`include "eaa_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module eaa_sync2 (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic d,
   output var  logic q
);
   import eaa_pkg::*;

   eaa_sync_st_t st_q;
   eaa_sync_st_t st_d;

   // First stage feeds only the second
   always_comb begin
      st_d    = st_q;
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign q = st_q.s2;

endmodule // eaa_sync2
`default_nettype wire

// ### core/eaa_top.sv
// Error alert aggregator: latches error and event flags, gates each with
// its report enable and ORs them onto an open-drain active-low alert on a
// multi-function pin. Assumes an APB master on clk and event pulses from
// logic on the same clock.
`include "eaa_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module eaa_top (
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output var  logic [31:0]           prdata,
   output var  logic                  pready,
   output var  logic                  pslverr,
   // Error sources
   input  wire eaa_pkg::eaa_evt_t     evt,
   input  wire logic [3:0]            dec_err_evt,
   input  wire logic [3:0]            link_locked,
   input  wire logic                  auto_err_rst,
   // Multi-function pin and interrupt
   input  wire logic                  mfp_in,
   output var  eaa_pkg::eaa_pin_t     multi_function_pin,
   output var  logic                  irq
);
   import eaa_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   eaa_top_st_t              st_q;
   eaa_top_st_t              st_d;
   logic [5:0]               idx;
   logic                     setup;
   logic                     rd_acc;
   logic                     wr_acc;
   logic                     mapped;
   logic [`EAA_NLINK-1:0]    dec_flag;
   logic [`EAA_NLINK-1:0]    cnt_clr;
   logic [7:0]               cnt [`EAA_NLINK];
   logic [`EAA_NSRC-1:0]     status;
   logic [`EAA_NSRC-1:0]     gated;
   logic                     alert_act;
   logic                     gpio_in;
   logic [31:0]              rd_mux;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------

   // Zero wait state: read data is captured in setup, so pready stays high
   assign idx     = paddr[7:2];
   assign setup   = psel && !penable;
   assign rd_acc  = psel && penable && !pwrite;
   assign wr_acc  = psel && penable && pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Only word-aligned hits on known indices are mapped
   always_comb begin
      mapped = 1'b0;
      if (paddr[1:0] == 2'b00) begin
         mapped = (idx >= `EAA_IDX_CTRL && idx <= `EAA_IDX_GPIO_IN) ||
                  (idx >= `EAA_IDX_CNT0 && idx <= `EAA_IDX_CNT_LAST);
      end
   end

   // ----------------------------------------
   // Decode-error counters, one per link
   // ----------------------------------------

   // Read-to-clear misses an error landing between setup and access and drops it;
   // an error in the access cycle itself is counted as one and kept
   generate
      for (genvar i = 0; i < `EAA_NLINK; i++) begin : g_link
         assign cnt_clr[i] = (rd_acc && mapped && idx == `EAA_IDX_CNT0 + 6'(i)) ||
                             auto_err_rst ||
                             (link_locked[i] && !st_q.lock_prev[i]);
         eaa_dec_counter u_cnt (
            .clk               (clk),
            .rst_b             (rst_b),
            .err_evt           (dec_err_evt[i]),
            .clr               (cnt_clr[i]),
            .thr               (st_q.thr),
            .cnt               (cnt[i]),
            .decode_fault_flag (dec_flag[i])
         );
      end
   endgenerate

   // ----------------------------------------
   // Pin input synchroniser
   // ----------------------------------------
   eaa_sync2 u_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (mfp_in),
      .q     (gpio_in)
   );

   // ----------------------------------------
   // Alert gating
   // ----------------------------------------

   // Every source stays visible in status even when its enable is off
   assign status    = {st_q.evt_flags, dec_flag};
   assign gated     = status & st_q.enable;
   assign alert_act = |gated;
   assign irq       = alert_act;

   // Alert mode is active low, open drain: only drives zero, idles via pull-up; GPIO mode drives gpio_out under gpio_oe
   always_comb begin
      if (st_q.pin_en) begin
         multi_function_pin.out = 1'b0;
         multi_function_pin.oe  = alert_act;
      end else begin
         multi_function_pin.out = st_q.gpio_out;
         multi_function_pin.oe  = st_q.gpio_oe;
      end
   end

   // ----------------------------------------
   // Read data mux
   // ----------------------------------------
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (idx == `EAA_IDX_CTRL) begin
         rd_mux[`EAA_CTRL_PIN_EN]   = st_q.pin_en;
         rd_mux[`EAA_CTRL_GPIO_OUT] = st_q.gpio_out;
         rd_mux[`EAA_CTRL_GPIO_OE]  = st_q.gpio_oe;
      end else if (idx == `EAA_IDX_FLAGS) begin
         rd_mux[`EAA_NSRC-1:0] = status;
      end else if (idx == `EAA_IDX_ENABLE) begin
         rd_mux[`EAA_NSRC-1:0] = st_q.enable;
      end else if (idx == `EAA_IDX_SUMMARY) begin
         rd_mux[0] = alert_act;
      end else if (idx == `EAA_IDX_THR) begin
         rd_mux[7:0] = st_q.thr;
      end else if (idx == `EAA_IDX_GPIO_IN) begin
         rd_mux[0] = gpio_in;
      end else if (idx >= `EAA_IDX_CNT0 && idx <= `EAA_IDX_CNT_LAST) begin
         rd_mux[7:0] = cnt[2'(idx - `EAA_IDX_CNT0)];
      end
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_d           = st_q;
      st_d.lock_prev = link_locked;
      if (setup) begin
         st_d.rdata = mapped ? rd_mux : 32'h0000_0000;
      end
      // Write-one-to-clear, but a new event in the same cycle wins
      if (wr_acc && mapped && idx == `EAA_IDX_FLAGS) begin
         st_d.evt_flags = st_q.evt_flags &
                          ~pwdata[`EAA_NSRC-1:`EAA_FL_EVT_LO];
      end
      st_d.evt_flags = st_d.evt_flags | evt;
      if (wr_acc && mapped) begin
         unique case (idx)
            `EAA_IDX_CTRL: begin
               st_d.pin_en   = pwdata[`EAA_CTRL_PIN_EN];
               st_d.gpio_out = pwdata[`EAA_CTRL_GPIO_OUT];
               st_d.gpio_oe  = pwdata[`EAA_CTRL_GPIO_OE];
            end
            `EAA_IDX_ENABLE: begin
               st_d.enable = pwdata[`EAA_NSRC-1:0];
            end
            `EAA_IDX_THR: begin
               st_d.thr = pwdata[7:0];
            end
            default: begin
               st_d.rdata = st_d.rdata;                                     // Flags (W1C above) or read-only index
            end
         endcase
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q           <= '0;
         st_q.pin_en    <= 1'b1;
         st_q.enable    <= `EAA_ENABLE_RST;
         st_q.thr       <= `EAA_THR_RST;
         st_q.lock_prev <= '1;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata = st_q.rdata;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic pin_level;
   assign pin_level = !(multi_function_pin.oe && !multi_function_pin.out);

   // Short name for the eye-monitor flag used by the clear checks
   logic eom_flag;
   assign eom_flag = st_q.evt_flags[`EAA_FL_EOM - `EAA_FL_EVT_LO];

   sequence s_lflt_enabled;
      evt.line_fault && st_q.enable[`EAA_FL_LFLT] && st_q.pin_en;
   endsequence

   sequence s_eom_held;
      st_q.evt_flags[`EAA_FL_EOM - `EAA_FL_EVT_LO] &&
      !(wr_acc && idx == `EAA_IDX_FLAGS && pwdata[`EAA_FL_EOM]);
   endsequence

   sequence s_read_cnt0;
      rd_acc && paddr == {`EAA_IDX_CNT0, 2'b00} && !dec_err_evt[0];
   endsequence

   sequence s_disable_all;
      wr_acc && paddr == {`EAA_IDX_ENABLE, 2'b00} && pwdata[`EAA_NSRC-1:0] == '0 && st_q.pin_en;
   endsequence

   AST_PIN_LOW_ACTIVE: assert property (st_q.pin_en && alert_act |-> !pin_level && multi_function_pin.oe)
      else $error("alert pin not pulled low");
   AST_PIN_RELEASED: assert property (st_q.pin_en && !alert_act |-> !multi_function_pin.oe)
      else $error("alert pin driven while idle");
   AST_SUMMARY_INVERSE: assert property (rd_acc && paddr == {`EAA_IDX_SUMMARY, 2'b00} && st_q.pin_en
                                          |-> prdata[0] == $past(!pin_level))
      else $error("summary bit not inverse of pin");
   AST_ENABLED_ALERTS: assert property (s_lflt_enabled ##1 $stable(st_q.enable) |-> !pin_level && irq)
      else $error("enabled error did not alert");
   AST_FLAG_HOLDS: assert property (s_eom_held |=> st_q.evt_flags[`EAA_FL_EOM - `EAA_FL_EVT_LO])
      else $error("latched flag lost");
   AST_DISABLED_RECORDS: assert property (evt.remote && !st_q.enable[`EAA_FL_REMOTE]
                                           |=> status[`EAA_FL_REMOTE])
      else $error("disabled source not recorded");
   AST_READ_CLEARS: assert property (s_read_cnt0 ##1 !auto_err_rst |-> cnt[0] == 8'h00)
      else $error("counter read did not clear");
   AST_DISABLE_DEASSERTS: assert property (s_disable_all |=> !irq && pin_level)
      else $error("alert stayed after disable");
   AST_GPIO_MODE: assert property (!st_q.pin_en |-> multi_function_pin.oe == st_q.gpio_oe &&
                                   multi_function_pin.out == st_q.gpio_out)
      else $error("pin not returned to gpio");

   // ----------------------------------------
   // Register writes, clears and routing
   // ----------------------------------------

   // A same-cycle enable write may legally mask the event, so it is left out
   sequence s_safety_enabled;
      evt.safety && st_q.enable[`EAA_NSRC-1] &&
      !(wr_acc && idx == `EAA_IDX_ENABLE);
   endsequence

   sequence s_eom_clear_collides;
      wr_acc && mapped && idx == `EAA_IDX_FLAGS && pwdata[`EAA_FL_EOM] && evt.eom;
   endsequence

   sequence s_eom_clear_alone;
      wr_acc && mapped && idx == `EAA_IDX_FLAGS && pwdata[`EAA_FL_EOM] && !evt.eom;
   endsequence

   // Clearing the only gated flag with nothing new arriving
   sequence s_last_eom_cleared;
      s_eom_clear_alone ##0 ($onehot(gated) && gated[`EAA_FL_EOM] && st_q.pin_en &&
                             evt == '0 && dec_err_evt == '0);
   endsequence

   sequence s_enable_write;
      wr_acc && mapped && idx == `EAA_IDX_ENABLE;
   endsequence

   sequence s_thr_write;
      wr_acc && mapped && idx == `EAA_IDX_THR;
   endsequence

   sequence s_ctrl_write;
      wr_acc && mapped && idx == `EAA_IDX_CTRL;
   endsequence

   // Sync path only means something after two clean edges out of reset
   sequence s_sync_warm;
      $past(rst_b) && $past(rst_b, 2);
   endsequence

   AST_SAFETY_ROUTES: assert property (s_safety_enabled |=> irq)
      else $error("safety event did not raise irq");
   AST_SET_BEATS_CLEAR: assert property (s_eom_clear_collides |=> eom_flag)
      else $error("event lost to same-cycle clear");
   AST_W1C_CLEARS: assert property (s_eom_clear_alone |=> !eom_flag)
      else $error("write-one did not clear flag");
   AST_LAST_CLEAR_DROPS: assert property (s_last_eom_cleared |=> !irq && pin_level)
      else $error("alert stayed after last clear");
   AST_NO_ENABLE_QUIET: assert property (st_q.enable == '0 && st_q.pin_en |-> !irq && !multi_function_pin.oe)
      else $error("alert without any enable");
   AST_ENABLE_WRITE: assert property (s_enable_write |=> st_q.enable == $past(pwdata[`EAA_NSRC-1:0]))
      else $error("enable write lost");
   AST_THR_WRITE: assert property (s_thr_write |=> st_q.thr == $past(pwdata[7:0]))
      else $error("threshold write lost");
   AST_CTRL_WRITE: assert property (s_ctrl_write |=> st_q.pin_en == $past(pwdata[`EAA_CTRL_PIN_EN]))
      else $error("pin enable write lost");
   AST_GPIO_SYNC: assert property (s_sync_warm |-> gpio_in == $past(mfp_in, 2))
      else $error("pin input not synchronised");

   // Every link's counter clears on relock and on the automatic reset;
   // threshold zero keeps the flag up on purpose, so it is left out
   generate
      for (genvar j = 0; j < `EAA_NLINK; j++) begin : g_clr_chk
         sequence s_relock;
            link_locked[j] && !st_q.lock_prev[j] && !dec_err_evt[j] && st_q.thr != 8'h00;
         endsequence

         AST_RELOCK_CLEARS: assert property (s_relock |=> cnt[j] == 8'h00 && !dec_flag[j])
            else $error("relock did not clear counter");
         AST_AUTO_CLEARS: assert property (auto_err_rst && !dec_err_evt[j] |=> cnt[j] == 8'h00)
            else $error("auto reset did not clear counter");
      end
   endgenerate

endmodule // eaa_top
`default_nettype wire
